//--- core/scpse_pkg.sv
package scpse_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_DIV_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PWR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STATUS   = 4'h8;

  localparam int UNLOCK_BIT  = 7;
  localparam int SLEEP_EN_BIT  = 5;
  localparam int MODE_HI_BIT   = 4;
  localparam int MODE_LO_BIT   = 3;
  localparam int BYTE_LANE0  = 0;

  localparam logic [7:0]  UNLOCK_CMD    = 8'h80;
  localparam logic [3:0]  DIV_RST_PLAIN = 4'h0;
  localparam logic [3:0]  DIV_RST_BY8   = 4'h3;
  localparam logic [3:0]  DIV_MAX       = 4'h8;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

  // ------------------------------------------------------------------
  // fuse codes
  // ------------------------------------------------------------------
  localparam logic [1:0] SRC_EXT   = 2'h0;
  localparam logic [1:0] SRC_RC_LO = 2'h1;
  localparam logic [1:0] SRC_RC_HI = 2'h2;
  localparam logic [1:0] SRC_LP    = 2'h3;
  localparam logic [1:0] STARTUP_CK    = 2'h0;
  localparam logic [1:0] STARTUP_4MS   = 2'h1;
  localparam logic [1:0] STARTUP_64MS  = 2'h2;

  typedef enum logic [1:0] {
    SLP_IDLE  = 2'h0,
    SLP_NOISE = 2'h1,
    SLP_PDOWN = 2'h2,
    SLP_RSVD  = 2'h3
  } scpse_sleep_t;

  typedef enum logic [2:0] {
    ST_RESET_DLY = 3'h0,
    ST_CK_DLY    = 3'h1,
    ST_RUN       = 3'h3,
    ST_SLEEP     = 3'h2,
    ST_WAKE_DLY  = 3'h6,
    ST_HALT      = 3'h7
  } scpse_state_t;

  typedef struct packed {
    logic       div8_prog;
    logic [1:0] startup;
    logic [1:0] src;
  } scpse_fuse_t;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
  } scpse_clk_en_t;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_4MS_NS      = 4_000_000;
  localparam int T_64MS_NS     = 64_000_000;
  localparam int CYC_4MS       = T_4MS_NS / CLK_PERIOD_NS;
  localparam int CYC_64MS      = T_64MS_NS / CLK_PERIOD_NS;
  localparam logic [2:0] UNLOCK_CYC  = 3'h4;
  localparam logic [2:0] HALT_TICKS  = 3'h4;
  localparam logic [4:0] PD_START_CK = 5'h06;
  localparam logic [4:0] RESET_CK    = 5'h0e;
  localparam logic [2:0] SETTLE_CYC  = 3'h4;
  localparam int SYNC_W = 8;

endpackage : scpse_pkg

//--- core/scpse_top.sv
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module scpse_top
  import scpse_pkg::*;
#(
  parameter int RST_4MS_CYC  = scpse_pkg::CYC_4MS,
  parameter int RST_64MS_CYC = scpse_pkg::CYC_64MS
)(
  input  wire logic                    clock_in,
  input  wire logic                    sys_rst_in,
  input  wire logic                    clk_en_in,
  input  wire scpse_pkg::scpse_fuse_t  fuse_in,
  input  wire logic                    external_clock_input_in,
  input  wire logic                    rc_osc_in,
  input  wire logic                    lp_osc_in,
  input  wire logic                    sleep_instr_in,
  input  wire logic                    wake_irq_in,
  input  wire logic [3:0]              avs_address_in,
  input  wire logic                    avs_read_in,
  input  wire logic                    avs_write_in,
  input  wire logic [3:0]              avs_byteenable_in,
  input  wire logic [31:0]             avs_writedata_in,
  output logic [31:0]                  avs_readdata_out,
  output logic                         avs_waitrequest_out,
  output scpse_pkg::scpse_clk_en_t     clk_en_out,
  output logic                         osc_enable_out,
  output logic                         cpu_reset_out,
  output logic                         cpu_halt_out
);
  import scpse_pkg::*;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [SYNC_W-1:0] pin_vec;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync3_reg;
  logic [SYNC_W-1:0] agree_reg;

  assign pin_vec = {fuse_in, lp_osc_in, rc_osc_in, external_clock_input_in};

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      agree_reg <= '0;
    end
    else if (clk_en_in)
    begin
      sync1_reg <= pin_vec;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      // a change only counts once the second and third stages agree
      agree_reg <= (~(sync2_reg ^ sync3_reg) & sync2_reg)
                 | ((sync2_reg ^ sync3_reg) & agree_reg);
    end
  end

  scpse_fuse_t fuse_sync;
  assign fuse_sync = agree_reg[SYNC_W-1:3];

  // ------------------------------------------------------------------
  // state, fuses and master clock edge
  // ------------------------------------------------------------------
  scpse_state_t state_reg;
  scpse_sleep_t slp_mode_reg;
  scpse_fuse_t  fuse_reg;
  logic         fuse_loaded_reg;
  logic [2:0]   settle_reg;
  logic         src_lvl;
  logic         src_prev_reg;
  logic         osc_on;
  logic         master_tick;
  logic         fuse_load;

  // the agree stage only holds the fuse levels one edge after the third flop fills
  assign fuse_load = (state_reg == ST_RESET_DLY) && !fuse_loaded_reg
                     && (settle_reg == SETTLE_CYC);

  always_comb
  begin
    case (fuse_reg.src)
      SRC_EXT:   src_lvl = agree_reg[0];
      SRC_RC_LO: src_lvl = agree_reg[1];
      SRC_RC_HI: src_lvl = agree_reg[1];
      SRC_LP:    src_lvl = agree_reg[2];
      default:   src_lvl = agree_reg[0];
    endcase
  end

  // power-down stops the oscillator, so no master edges reach the divider
  assign osc_on      = !((state_reg == ST_SLEEP) && (slp_mode_reg == SLP_PDOWN));
  // the source is assumed to change rate slowly, so every edge is one CK
  assign master_tick = src_lvl && !src_prev_reg && osc_on;

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      src_prev_reg <= 1'b0;
    else if (clk_en_in)
      src_prev_reg <= src_lvl;
  end

  // ------------------------------------------------------------------
  // ripple divider
  // ------------------------------------------------------------------
  logic [7:0] ripple_reg;
  logic [7:0] carry;
  logic [3:0] div_sel_reg;
  logic [3:0] active_div_reg;
  logic [3:0] pend_div_reg;
  logic       pend_valid_reg;
  logic [7:0] div_mask;
  logic       div_tick;
  logic       div_switch;

  function automatic logic [7:0] mask_of(input logic [3:0] n);
    logic [8:0] m;
    m = (9'h001 << n) - 9'h001;
    return m[7:0];
  endfunction : mask_of

  assign div_mask   = mask_of(active_div_reg);
  assign div_tick   = master_tick && ((ripple_reg & div_mask) == div_mask);
  // a new ratio is taken only where the old period ends: no short pulse
  assign div_switch = div_tick && pend_valid_reg;
  assign carry[0]   = master_tick;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_ripple
      if (gi > 0)
      begin : g_carry
        assign carry[gi] = carry[gi-1] && ripple_reg[gi-1];
      end
      always_ff @(posedge clock_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
          ripple_reg[gi] <= 1'b0;
        else if (clk_en_in)
        begin
          if (div_switch || fuse_load)
            ripple_reg[gi] <= 1'b0;
          else if (carry[gi])
            ripple_reg[gi] <= ~ripple_reg[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------------
  logic        waitrequest_reg;
  logic [31:0] readdata_reg;
  logic        wr_take;
  logic        wr_div;
  logic        wr_pwr;
  logic        unlock_reg;
  logic [2:0]  unlock_cnt_reg;
  logic        sleep_enable_reg;
  logic [1:0]  sleep_mode_reg;
  logic [7:0]  wbyte;

  assign wbyte   = avs_writedata_in[7:0];
  assign wr_take = avs_write_in && !waitrequest_reg && avs_byteenable_in[BYTE_LANE0];
  assign wr_div  = wr_take && (avs_address_in == ADDR_DIV_CTRL);
  assign wr_pwr  = wr_take && (avs_address_in == ADDR_PWR_CTRL);

  // one wait cycle for every request, answer on the second
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      waitrequest_reg <= 1'b1;
      readdata_reg    <= RDATA_ZERO;
    end
    else if (clk_en_in)
    begin
      waitrequest_reg <= !((avs_read_in || avs_write_in) && waitrequest_reg);
      if (avs_read_in && waitrequest_reg)
      begin
        case (avs_address_in)
          ADDR_DIV_CTRL: readdata_reg <= 32'({unlock_reg, 3'h0, div_sel_reg});
          ADDR_PWR_CTRL: readdata_reg <= 32'({sleep_enable_reg, sleep_mode_reg, 3'h0});
          ADDR_STATUS:   readdata_reg <= 32'({cpu_halt_out, active_div_reg,
                                              cpu_reset_out, slp_mode_reg,
                                              state_reg == ST_SLEEP});
          default:       readdata_reg <= RDATA_ZERO;
        endcase
      end
    end
  end

  // protected change window
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      unlock_reg     <= 1'b0;
      unlock_cnt_reg <= 3'h0;
    end
    else if (clk_en_in)
    begin
      if (wr_div && !unlock_reg && (wbyte == UNLOCK_CMD))
      begin
        unlock_reg     <= 1'b1;
        unlock_cnt_reg <= UNLOCK_CYC;
      end
      else if (unlock_reg)
      begin
        if ((wr_div && !wbyte[UNLOCK_BIT]) || (unlock_cnt_reg == 3'h1))
        begin
          unlock_reg     <= 1'b0;
          unlock_cnt_reg <= 3'h0;
        end
        else
          unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
      end
    end
  end

  // select value and the ratio in use
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      div_sel_reg    <= DIV_RST_PLAIN;
      active_div_reg <= DIV_RST_PLAIN;
      pend_div_reg   <= DIV_RST_PLAIN;
      pend_valid_reg <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (fuse_load)
      begin
        div_sel_reg    <= fuse_sync.div8_prog ? DIV_RST_BY8 : DIV_RST_PLAIN;
        active_div_reg <= fuse_sync.div8_prog ? DIV_RST_BY8 : DIV_RST_PLAIN;
      end
      else if (wr_div && unlock_reg && !wbyte[UNLOCK_BIT])
      begin
        div_sel_reg <= wbyte[3:0];
        if (wbyte[3:0] <= DIV_MAX)
        begin
          pend_div_reg   <= wbyte[3:0];
          pend_valid_reg <= 1'b1;
        end
      end
      else if (div_switch)
      begin
        active_div_reg <= pend_div_reg;
        pend_valid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sleep_enable_reg <= 1'b0;
      sleep_mode_reg   <= 2'h0;
    end
    else if (clk_en_in && wr_pwr)
    begin
      sleep_enable_reg <= wbyte[SLEEP_EN_BIT];
      sleep_mode_reg   <= wbyte[MODE_HI_BIT:MODE_LO_BIT];
    end
  end

  // ------------------------------------------------------------------
  // start-up and sleep sequencer
  // ------------------------------------------------------------------
  logic [23:0] rt_cnt_reg;
  logic [4:0]  ck_cnt_reg;
  logic [2:0]  halt_cnt_reg;
  logic [23:0] rt_load;

  always_comb
  begin
    case (fuse_sync.startup)
      STARTUP_CK:   rt_load = 24'h0;
      STARTUP_4MS:  rt_load = 24'(RST_4MS_CYC);
      STARTUP_64MS: rt_load = 24'(RST_64MS_CYC);
      // reserved code gets the longest, safest delay
      default:  rt_load = 24'(RST_64MS_CYC);
    endcase
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_reg       <= ST_RESET_DLY;
      slp_mode_reg    <= SLP_IDLE;
      fuse_reg        <= '0;
      fuse_loaded_reg <= 1'b0;
      settle_reg      <= 3'h0;
      rt_cnt_reg      <= 24'h0;
      ck_cnt_reg      <= 5'h0;
      halt_cnt_reg    <= 3'h0;
    end
    else if (clk_en_in)
    begin
      case (state_reg)
        ST_RESET_DLY:
        begin
          if (!fuse_loaded_reg)
          begin
            settle_reg <= settle_reg + 3'h1;
            if (fuse_load)
            begin
              fuse_reg        <= fuse_sync;
              fuse_loaded_reg <= 1'b1;
              rt_cnt_reg      <= rt_load;
            end
          end
          else if (rt_cnt_reg != 24'h0)
            rt_cnt_reg <= rt_cnt_reg - 24'h1;
          else
          begin
            ck_cnt_reg <= RESET_CK;
            state_reg  <= ST_CK_DLY;
          end
        end
        ST_CK_DLY, ST_WAKE_DLY:
        begin
          if (master_tick)
          begin
            if (ck_cnt_reg == 5'h01)
            begin
              state_reg    <= (state_reg == ST_CK_DLY) ? ST_RUN : ST_HALT;
              halt_cnt_reg <= HALT_TICKS;
            end
            else
              ck_cnt_reg <= ck_cnt_reg - 5'h01;
          end
        end
        ST_RUN:
        begin
          if (sleep_instr_in && sleep_enable_reg
              && (scpse_sleep_t'(sleep_mode_reg) != SLP_RSVD))
          begin
            slp_mode_reg <= scpse_sleep_t'(sleep_mode_reg);
            state_reg    <= ST_SLEEP;
          end
        end
        ST_SLEEP:
        begin
          if (wake_irq_in)
          begin
            // only power-down restarts the oscillator and needs start-up
            if (slp_mode_reg == SLP_PDOWN)
            begin
              ck_cnt_reg <= PD_START_CK;
              state_reg  <= ST_WAKE_DLY;
            end
            else
            begin
              halt_cnt_reg <= HALT_TICKS;
              state_reg    <= ST_HALT;
            end
          end
        end
        ST_HALT:
        begin
          if (div_tick)
          begin
            if (halt_cnt_reg == 3'h1)
              state_reg <= ST_RUN;
            else
              halt_cnt_reg <= halt_cnt_reg - 3'h1;
          end
        end
        default: state_reg <= ST_RESET_DLY;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // clock domain enables
  // ------------------------------------------------------------------
  scpse_clk_en_t clk_en_next;
  logic          run_io;

  // sleep only gates clock enables and, in power-down, the oscillator; core and memory state simply freeze
  assign run_io = (state_reg == ST_RUN) || (state_reg == ST_HALT)
                  || ((state_reg == ST_SLEEP) && (slp_mode_reg == SLP_IDLE));

  always_comb
  begin
    clk_en_next.cpu   = div_tick && (state_reg == ST_RUN);
    clk_en_next.flash = div_tick && (state_reg == ST_RUN);
    clk_en_next.io    = div_tick && run_io;
    clk_en_next.adc   = div_tick && (run_io || ((state_reg == ST_SLEEP)
                        && (slp_mode_reg == SLP_NOISE)));
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      clk_en_out     <= '0;
      osc_enable_out <= 1'b1;
      cpu_reset_out  <= 1'b1;
      cpu_halt_out   <= 1'b0;
    end
    else if (clk_en_in)
    begin
      clk_en_out     <= clk_en_next;
      osc_enable_out <= osc_on;
      cpu_reset_out  <= (state_reg == ST_RESET_DLY) || (state_reg == ST_CK_DLY);
      cpu_halt_out   <= (state_reg == ST_SLEEP) || (state_reg == ST_WAKE_DLY)
                        || (state_reg == ST_HALT);
    end
  end

  assign avs_readdata_out    = readdata_reg;
  assign avs_waitrequest_out = waitrequest_reg;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  AST_UNLOCK_ONLY_ZERO: assert property (
    (clk_en_in && wr_div && !unlock_reg && (wbyte != UNLOCK_CMD)) |=> !unlock_reg)
    else $error("unlock set by a write with other bits nonzero");
  AST_UNLOCK_WINDOW: assert property (
    unlock_reg |-> (unlock_cnt_reg != 3'h0) && (unlock_cnt_reg <= UNLOCK_CYC))
    else $error("unlock window count out of range");
  AST_UNLOCK_NO_RESTART: assert property (
    (clk_en_in && unlock_reg && wr_div && wbyte[UNLOCK_BIT] && (unlock_cnt_reg > 3'h1))
    |=> unlock_reg && (unlock_cnt_reg == $past(unlock_cnt_reg) - 3'h1))
    else $error("unlock rewrite restarted or cleared the window");
  AST_RSVD_ZERO: assert property (
    (avs_read_in && !waitrequest_reg && (avs_address_in == ADDR_DIV_CTRL))
    |-> (avs_readdata_out[6:4] == 3'h0))
    else $error("reserved divider bits read nonzero");
  AST_RSVD_DIV_KEEP: assert property (
    active_div_reg <= DIV_MAX)
    else $error("reserved division code became active");
  AST_SWITCH_ON_BOUNDARY: assert property (
    (state_reg == ST_RUN) && $changed(active_div_reg) |-> $past(div_switch))
    else $error("division changed away from a period boundary");
  AST_SLEEP_NEEDS_SE: assert property (
    (clk_en_in && (state_reg == ST_RUN) && sleep_instr_in && !sleep_enable_reg)
    |=> (state_reg == ST_RUN))
    else $error("sleep entered without sleep enable");
  AST_PD_OSC_OFF: assert property (
    ((state_reg == ST_SLEEP) && (slp_mode_reg == SLP_PDOWN) && clk_en_in)[*2]
    |-> !osc_enable_out && !clk_en_out.io)
    else $error("oscillator running in power-down");
  AST_HALT_FOUR: assert property (
    $rose(state_reg == ST_HALT) |-> (state_reg == ST_HALT)[*4])
    else $error("cpu released before four halt cycles");
  AST_CPU_STOPPED: assert property (
    ((state_reg == ST_SLEEP) && clk_en_in) |=> !clk_en_out.cpu && !clk_en_out.flash)
    else $error("cpu clock running in sleep");

  COV_UNLOCK_CHANGE: cover property (unlock_reg ##[1:4] (wr_div && !wbyte[UNLOCK_BIT]));
  COV_SWITCH:        cover property (div_switch);
  COV_PD_SLEEP:      cover property ((state_reg == ST_SLEEP) && (slp_mode_reg == SLP_PDOWN));
  COV_WAKE_RUN:      cover property ((state_reg == ST_HALT) ##1 (state_reg == ST_RUN));

endmodule : scpse_top

//--- sim/scpse_ext_clk.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// external clock source on the clock pin
// ------------------------------------------------------------
module scpse_ext_clk (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] half_in,
  output logic            clk_out
);
  logic [3:0] cnt_reg;
  logic       clk_reg;
  // half period only changes under reset, so no cycle-to-cycle step
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_reg <= 4'h0;
      clk_reg <= 1'b0;
    end
    else if (cnt_reg >= half_in - 4'h1)
    begin
      cnt_reg <= 4'h0;
      clk_reg <= ~clk_reg;
    end
    else
      cnt_reg <= cnt_reg + 4'h1;
  end
  assign clk_out = clk_reg;
endmodule : scpse_ext_clk

//--- sim/tb_top.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// register sequences against the clock controller
// ------------------------------------------------------------
module tb_top;
  import scpse_pkg::*;
  localparam int P = 8;
  logic          clock_in, sys_rst_in, ext_clk, rd, wr, slp, wake, ce;
  logic          wait_o, osc_o, rst_o, halt_o;
  logic [3:0]    addr, seen, be;
  logic [31:0]   wdata, rdata, q;
  scpse_clk_en_t en_o;
  scpse_fuse_t   fuse;
  int            fails, total_checks, n, g, w;

  scpse_top #(.RST_4MS_CYC(20), .RST_64MS_CYC(40)) i_scpse_top (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(ce),
    .fuse_in(fuse), .external_clock_input_in(ext_clk), .rc_osc_in(1'b0),
    .lp_osc_in(1'b0), .sleep_instr_in(slp), .wake_irq_in(wake),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_byteenable_in(be), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
    .clk_en_out(en_o), .osc_enable_out(osc_o),
    .cpu_reset_out(rst_o), .cpu_halt_out(halt_o));
  scpse_ext_clk i_scpse_ext_clk (.clock_in(clock_in), .rst_in(sys_rst_in),
    .half_in(4'h4), .clk_out(ext_clk));

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
    end
  endtask : check

  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= {24'h00_0000, d};
    wr <= w;
    rd <= !w;
    do
      @(posedge clock_in);
    while (wait_o !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock_in);
  endtask : bus

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    check(q, e);
  endtask : rchk

  task automatic set_div(input logic [3:0] v);
    bus(1'b1, ADDR_DIV_CTRL, UNLOCK_CMD);
    bus(1'b1, ADDR_DIV_CTRL, {4'h0, v});
  endtask : set_div

  task automatic collect;
    seen = 4'h0;
    repeat (100)
    begin
      @(posedge clock_in);
      seen = seen | en_o;
    end
  endtask : collect

  // edges between two io pulses
  task automatic gap(output int c);
    c = 0;
    while (en_o.io !== 1'b1)
    begin
      @(posedge clock_in);
      c++;
    end
    c = 0;
    do
    begin
      @(posedge clock_in);
      c++;
    end
    while (en_o.io !== 1'b1);
  endtask : gap

  task automatic wait_low(ref logic s);
    n = 0;
    while (s !== 1'b0)
    begin
      @(posedge clock_in);
      n++;
    end
  endtask : wait_low

  task automatic pulse_sleep;
    slp <= 1'b1;
    @(posedge clock_in);
    slp <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask : pulse_sleep

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  initial
  begin
    #200_000;
    fails++;
    wrap_up();
  end

  initial
  begin
    {sys_rst_in, rd, wr, slp, wake, addr, wdata} = {5'h10, 4'h0, 32'h0000_0000};
    ce = 1'b1;
    be = 4'h1;
    fuse = {1'b1, STARTUP_4MS, SRC_EXT};
    repeat (10) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    wait_low(rst_o);
    // first external edge lands anywhere within one period
    check(n >= 20 + 13 * P && n <= 20 + 14 * P + 30, 1'b1);
    rchk(ADDR_DIV_CTRL, 32'h0000_0003);
    bus(1'b1, ADDR_DIV_CTRL, 8'h81);
    rchk(ADDR_DIV_CTRL, 32'h0000_0003);
    bus(1'b1, ADDR_DIV_CTRL, UNLOCK_CMD);
    rchk(ADDR_DIV_CTRL, 32'h0000_0083);
    rchk(ADDR_DIV_CTRL, 32'h0000_0003);
    bus(1'b1, ADDR_DIV_CTRL, UNLOCK_CMD);
    bus(1'b1, ADDR_DIV_CTRL, UNLOCK_CMD);
    rchk(ADDR_DIV_CTRL, 32'h0000_0003);
    bus(1'b1, ADDR_DIV_CTRL, UNLOCK_CMD);
    repeat (4) @(posedge clock_in);
    bus(1'b1, ADDR_DIV_CTRL, 8'h05);
    rchk(ADDR_DIV_CTRL, 32'h0000_0003);
    be <= 4'h0;
    bus(1'b1, ADDR_DIV_CTRL, UNLOCK_CMD);
    be <= 4'h1;
    rchk(ADDR_DIV_CTRL, 32'h0000_0003);
    // window counts enabled cycles only, so a frozen stretch keeps it open
    bus(1'b1, ADDR_DIV_CTRL, UNLOCK_CMD);
    ce <= 1'b0;
    repeat (8) @(posedge clock_in);
    ce <= 1'b1;
    bus(1'b1, ADDR_DIV_CTRL, 8'h02);
    rchk(ADDR_DIV_CTRL, 32'h0000_0002);
    $display("test unlock done");
    for (int i = 0; i <= 8; i++)
    begin
      set_div(4'(i));
      rchk(ADDR_DIV_CTRL, i);
      gap(g);
      gap(g);
      check(g, P << i);
      rchk(ADDR_STATUS, i << 4);
    end
    set_div(4'h9);
    rchk(ADDR_DIV_CTRL, 32'h0000_0009);
    rchk(ADDR_STATUS, 32'h0000_0080);
    set_div(4'h0);
    gap(g);
    gap(g);
    check(g, P);
    collect();
    check(seen, 4'hf);
    $display("test divider done");
    bus(1'b1, ADDR_PWR_CTRL, 8'h00);
    pulse_sleep();
    rchk(ADDR_STATUS, 32'h0000_0000);
    for (int m = 0; m < 3; m++)
    begin
      bus(1'b1, ADDR_PWR_CTRL, 8'(32'h20 | (m << 3)));
      pulse_sleep();
      collect();
      check(seen, (m == 0) ? 4'h3 : (m == 1) ? 4'h1 : 4'h0);
      check(osc_o, m != 2);
      rchk(ADDR_STATUS, 32'h101 | (m << 1));
      // power-down adds six source ticks of start-up before the halt ticks
      w = (m == 2) ? 6 * P : 0;
      wake <= 1'b1;
      wait_low(halt_o);
      wake <= 1'b0;
      check(n >= 3 * P + 4 + w && n <= 4 * P + 3 + w, 1'b1);
      rchk(ADDR_PWR_CTRL, 32'h20 | (m << 3));
    end
    $display("test sleep done");
    pulse_sleep();
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    check({rst_o, halt_o}, 2'b10);
    wait_low(rst_o);
    check(n >= 20 + 13 * P && n <= 20 + 14 * P + 30, 1'b1);
    rchk(ADDR_DIV_CTRL, 32'h0000_0003);
    $display("test reset in sleep done");
    wrap_up();
  end
endmodule : tb_top
